// >>> shared/sso_map.vh
// sso_map.vh: register offsets, field positions, opcodes and reset values
// for the halt and subtract executor; definitions only
`ifndef SSO_MAP_VH
`define SSO_MAP_VH

// register byte offsets (low address byte)
`define SSO_OFS_INSTR      8'h00
`define SSO_OFS_WORK       8'h04
`define SSO_OFS_STATUS     8'h08
`define SSO_OFS_FILE_BASE  2'h1
`define SSO_FILE_DEPTH     16

// status field positions
`define SSO_ST_BORROW_NOT  0
`define SSO_ST_HALF_BORROW 1
`define SSO_ST_NIL         2
`define SSO_ST_SPILL       3
`define SSO_ST_SLEEP_N     4
`define SSO_ST_WDT_N       5
`define SSO_ST_BUSY        6
`define SSO_ST_ASLEEP      7
`define SSO_ST_BAD_OP      8

// reset values
`define SSO_RST_WORK       8'h00
`define SSO_RST_INSTR      16'h0000
`define SSO_RST_SLEEP_N    1'b1
`define SSO_RST_WDT_N      1'b1

// opcode patterns
`define SSO_OP_HALT        16'h0003
`define SSO_OP_LIT_SUB_HI  8'hB2
`define SSO_OP_FSUB_HI     7'h02
`define SSO_OP_FSUBB_HI    7'h01

// instruction phases, four per instruction cycle
`define SSO_Q1             2'h0
`define SSO_Q2             2'h1
`define SSO_Q3             2'h2
`define SSO_Q4             2'h3

// bus constants
`define SSO_HSIZE_WORD     3'h2

`endif

// >>> rtl/sso_sub_alu.v
// sso_sub_alu.v: 8-bit two's complement subtractor with flag outputs
// assumes operands are stable from flip-flops in the caller's clock
`timescale 1ns/10ps
`default_nettype none
module sso_sub_alu (
   // operands
   input  wire [7:0] minuend,
   input  wire [7:0] subtrahend,
   input  wire       carry_in,
   // result and flags
   output wire [7:0] diff,
   output wire       borrow_not,
   output wire       half_borrow_not,
   output wire       spill,
   output wire       nil
);

   wire [8:0] full_sum;
   wire [4:0] low_sum;

   // minuend plus inverted subtrahend plus carry [RQ12]
   assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
   assign low_sum  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]}
                     + {4'h0, carry_in};
   // negative difference leaves the two's complement byte [RQ11]
   assign diff            = full_sum[7:0];
   // carry out set means no borrow [RQ10] [RQ11]
   assign borrow_not      = full_sum[8];
   assign half_borrow_not = low_sum[4];
   // signed overflow: operand signs differ and result sign flips
   assign spill = (minuend[7] ^ subtrahend[7]) & (diff[7] ^ minuend[7]);
   // zero result detect [RQ15]
   assign nil   = (diff == 8'h00);

endmodule
`default_nettype wire

// >>> rtl/sso_core.v
// sso_core.v: halt and subtract instruction executor with ahb-lite slave
// assumes one ahb-lite master on hclk; wake pins arrive asynchronously
// Notes on behaviour
// [RQ1] opcode 0x0003 is the single-word halt instruction
// [RQ2] halt clears the active-low sleep entered bit
// [RQ3] halt sets the active-low watchdog expiry bit; only those two change; the core also sets the asleep bit and clears the bad opcode bit
// [RQ4] halt clears watchdog count and postscaler
// [RQ5] after halt oscillator stops and execution ceases until wake-up
// [RQ6] watchdog wake-up clears the active-low watchdog expiry bit
// [RQ7] upper byte 0xB2 is literal minus work, low byte is literal
// [RQ8] literal minus work writes result to work register in one cycle
// [RQ9] subtracts update spill, borrow-not, half borrow, nil flags only
// [RQ10] borrow-not is one when difference is zero or positive
// [RQ11] negative difference gives two's complement and clears borrow-not
// [RQ12] file minus work with borrow also subtracts inverted borrow-not
// [RQ13] d bit zero writes work register, one writes file register
// [RQ14] file minus work: one cycle, same flags, destination by d
// [RQ15] nil flag set when the 8-bit result is zero
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "sso_map.vh"
module sso_core (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output wire [31:0] hrdata,
   // watchdog and oscillator control
   output wire        wdt_clear,
   output wire        osc_stop,
   // wake-up pins
   input  wire        wake_wdt,
   input  wire        wake_evt
);

   localparam K_BAD   = 3'h0;
   localparam K_HALT  = 3'h1;
   localparam K_LSUB  = 3'h2;
   localparam K_FSUB  = 3'h3;
   localparam K_FSUBB = 3'h4;

   // bus phase state
   reg  [7:0]  ahb_addr_r;
   reg         ahb_wr_r;
   reg         rd_wait_r;
   reg  [31:0] hrdata_r;
   reg  [31:0] rd_mux;
   wire        ahb_acc;

   // execution state
   reg  [15:0] ir_r;
   reg  [7:0]  work_r;
   reg  [7:0]  file_r [0:`SSO_FILE_DEPTH-1];
   reg         run_r;
   reg  [1:0]  phase_r;
   reg  [2:0]  kind_r;
   reg  [7:0]  opnd_r;
   reg  [7:0]  res_r;
   reg         res_c_r;
   reg         res_dc_r;
   reg         res_ov_r;
   reg         res_z_r;
   reg         c_r;
   reg         dc_r;
   reg         z_r;
   reg         ov_r;
   reg         sleep_n_r;
   reg         wdt_n_r;
   reg         asleep_r;
   reg         bad_r;
   reg         wdt_clear_r;

   // wake synchronisers
   reg  [1:0]  wk_s1_r;
   reg  [1:0]  wk_s2_r;
   reg  [1:0]  wk_s3_r;
   wire        wake_wdt_lvl;
   wire        wake_evt_lvl;

   // decoded strobes
   wire        wr_instr;
   wire        wr_work;
   wire        wr_status;
   wire        wr_file;
   wire [3:0]  bus_idx;
   wire        start;
   wire        is_sub;
   wire        q4_sub;
   wire        dest_file;
   wire [3:0]  f_idx;
   wire [7:0]  alu_diff;
   wire        alu_c;
   wire        alu_dc;
   wire        alu_ov;
   wire        alu_z;
   wire        alu_cin;
   wire [2:0]  dec_kind;

   // bus address phase capture, reads take one wait state
   assign ahb_acc = hsel & hready & htrans[1] & (hsize == `SSO_HSIZE_WORD);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ahb_addr_r <= 8'h00;
         ahb_wr_r   <= 1'b0;
         rd_wait_r  <= 1'b0;
         hrdata_r   <= 32'h00000000;
      end else begin
         ahb_wr_r  <= ahb_acc & hwrite;
         rd_wait_r <= ahb_acc & ~hwrite;
         if (ahb_acc) begin
            ahb_addr_r <= haddr[7:0];
         end
         if (rd_wait_r) begin
            hrdata_r <= rd_mux;
         end
      end
   end

   assign hreadyout = ~rd_wait_r;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;

   // register decode
   assign bus_idx   = ahb_addr_r[5:2];
   assign wr_instr  = ahb_wr_r & (ahb_addr_r == `SSO_OFS_INSTR);
   assign wr_work   = ahb_wr_r & (ahb_addr_r == `SSO_OFS_WORK);
   assign wr_status = ahb_wr_r & (ahb_addr_r == `SSO_OFS_STATUS);
   assign wr_file   = ahb_wr_r & (ahb_addr_r[7:6] == `SSO_OFS_FILE_BASE);

   // read data select, unmapped reads as zero
   always @* begin
      rd_mux = 32'h00000000;
      if (ahb_addr_r == `SSO_OFS_INSTR) begin
         rd_mux = {16'h0000, ir_r};
      end else if (ahb_addr_r == `SSO_OFS_WORK) begin
         rd_mux = {24'h000000, work_r};
      end else if (ahb_addr_r == `SSO_OFS_STATUS) begin
         rd_mux[`SSO_ST_BORROW_NOT]  = c_r;
         rd_mux[`SSO_ST_HALF_BORROW] = dc_r;
         rd_mux[`SSO_ST_NIL]         = z_r;
         rd_mux[`SSO_ST_SPILL]       = ov_r;
         rd_mux[`SSO_ST_SLEEP_N]     = sleep_n_r;
         rd_mux[`SSO_ST_WDT_N]       = wdt_n_r;
         rd_mux[`SSO_ST_BUSY]        = run_r;
         rd_mux[`SSO_ST_ASLEEP]      = asleep_r;
         rd_mux[`SSO_ST_BAD_OP]      = bad_r;
      end else if (ahb_addr_r[7:6] == `SSO_OFS_FILE_BASE) begin
         rd_mux = {24'h000000, file_r[bus_idx]};
      end
   end

   // wake pins: three flops, level counts once second and third agree
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wk_s1_r <= 2'h0;
         wk_s2_r <= 2'h0;
         wk_s3_r <= 2'h0;
      end else begin
         wk_s1_r <= {wake_evt, wake_wdt};
         wk_s2_r <= wk_s1_r;
         wk_s3_r <= wk_s2_r;
      end
   end

   assign wake_wdt_lvl = wk_s2_r[0] & wk_s3_r[0];
   assign wake_evt_lvl = wk_s2_r[1] & wk_s3_r[1];

   // instruction decode
   assign dec_kind =
      (ir_r == `SSO_OP_HALT)             ? K_HALT :  // [RQ1]
      (ir_r[15:8] == `SSO_OP_LIT_SUB_HI) ? K_LSUB :  // [RQ7]
      (ir_r[15:9] == `SSO_OP_FSUB_HI)    ? K_FSUB :
      (ir_r[15:9] == `SSO_OP_FSUBB_HI)   ? K_FSUBB : K_BAD;

   // no new instruction while asleep or running [RQ5]
   assign start     = wr_instr & ~run_r & ~asleep_r;
   assign is_sub    = (kind_r == K_LSUB) | (kind_r == K_FSUB)
                      | (kind_r == K_FSUBB);
   assign q4_sub    = run_r & (phase_r == `SSO_Q4) & is_sub;
   // destination bit selects file or work [RQ13]
   assign dest_file = (kind_r != K_LSUB) & ir_r[8];
   assign f_idx     = ir_r[3:0];
   // borrow form feeds the stored borrow-not as carry [RQ12]
   assign alu_cin   = (kind_r == K_FSUBB) ? c_r : 1'b1;

   sso_sub_alu u_alu (
      .minuend         (opnd_r),
      .subtrahend      (work_r),
      .carry_in        (alu_cin),
      .diff            (alu_diff),
      .borrow_not      (alu_c),
      .half_borrow_not (alu_dc),
      .spill           (alu_ov),
      .nil             (alu_z)
   );

   // four-phase sequencer: decode, read, execute, write
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ir_r        <= `SSO_RST_INSTR;
         run_r       <= 1'b0;
         phase_r     <= `SSO_Q1;
         kind_r      <= K_BAD;
         opnd_r      <= 8'h00;
         res_r       <= 8'h00;
         res_c_r     <= 1'b0;
         res_dc_r    <= 1'b0;
         res_ov_r    <= 1'b0;
         res_z_r     <= 1'b0;
         bad_r       <= 1'b0;
         wdt_clear_r <= 1'b0;
      end else begin
         wdt_clear_r <= 1'b0;
         if (start) begin
            ir_r    <= hwdata[15:0];
            run_r   <= 1'b1;
            phase_r <= `SSO_Q1;
         end else if (run_r) begin
            phase_r <= phase_r + 2'h1;
            case (phase_r)
               `SSO_Q1: begin
                  kind_r <= dec_kind;
                  bad_r  <= (dec_kind == K_BAD);
               end
               `SSO_Q2: begin
                  // literal operand or addressed file byte
                  opnd_r <= (kind_r == K_LSUB) ? ir_r[7:0] : file_r[f_idx];
               end
               `SSO_Q3: begin
                  res_r    <= alu_diff;
                  res_c_r  <= alu_c;
                  res_dc_r <= alu_dc;
                  res_ov_r <= alu_ov;
                  res_z_r  <= alu_z;
                  if (kind_r == K_HALT) begin
                     wdt_clear_r <= 1'b1;  // [RQ4]
                  end
               end
               `SSO_Q4: begin
                  run_r <= 1'b0;
               end
               default: begin
                  run_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // status flags, instruction result wins over a bus write
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         c_r  <= 1'b0;
         dc_r <= 1'b0;
         z_r  <= 1'b0;
         ov_r <= 1'b0;
      end else if (q4_sub) begin
         c_r  <= res_c_r;  // [RQ9] [RQ10] [RQ11]
         dc_r <= res_dc_r; // [RQ9]
         z_r  <= res_z_r;  // [RQ15]
         ov_r <= res_ov_r; // [RQ9]
      end else if (wr_status) begin
         c_r  <= hwdata[`SSO_ST_BORROW_NOT];
         dc_r <= hwdata[`SSO_ST_HALF_BORROW];
         z_r  <= hwdata[`SSO_ST_NIL];
         ov_r <= hwdata[`SSO_ST_SPILL];
      end
   end

   // power status and sleep state
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleep_n_r <= `SSO_RST_SLEEP_N;
         wdt_n_r   <= `SSO_RST_WDT_N;
         asleep_r  <= 1'b0;
      end else if (run_r & (phase_r == `SSO_Q3) & (kind_r == K_HALT)) begin
         sleep_n_r <= 1'b0;  // [RQ2]
         wdt_n_r   <= 1'b1;  // [RQ3]
         asleep_r  <= 1'b1;  // [RQ5]
      end else if (asleep_r & (wake_wdt_lvl | wake_evt_lvl)) begin
         asleep_r <= 1'b0;
         if (wake_wdt_lvl) begin
            wdt_n_r <= 1'b0;  // [RQ6]
         end
      end
   end

   // working register: work destination or literal form [RQ8] [RQ13]
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         work_r <= `SSO_RST_WORK;
      end else if (q4_sub & ~dest_file) begin
         work_r <= res_r;  // [RQ14]
      end else if (wr_work) begin
         work_r <= hwdata[7:0];
      end
   end

   // file register bytes, one flop group per entry
   genvar gi;
   generate
      for (gi = 0; gi < `SSO_FILE_DEPTH; gi = gi + 1) begin : g_file
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               file_r[gi] <= 8'h00;
            end else if (q4_sub & dest_file & (f_idx == gi)) begin
               file_r[gi] <= res_r;  // [RQ13] [RQ14]
            end else if (wr_file & (bus_idx == gi)) begin
               file_r[gi] <= hwdata[7:0];
            end
         end
      end
   endgenerate

   assign wdt_clear = wdt_clear_r;
   assign osc_stop  = asleep_r;

endmodule
`default_nettype wire

// >>> sim/sso_core_props.sv
// sso_core_props.sv: bus and halt checks on sso_core ports
// assumes hready fed from hreadyout and word transfers only
`timescale 1ns/10ps
`default_nettype none
module sso_props (
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // control and wake
   input wire logic        wdt_clear,
   input wire logic        osc_stop,
   input wire logic        wake_wdt,
   input wire logic        wake_evt
);
   wire req = hsel && hready && htrans[1] && hsize == 3'h2;
   wire wake_any = wake_wdt | wake_evt;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence instr_wr_s;
      req && hwrite && haddr[7:0] == 8'h00 && !osc_stop;
   endsequence
   sequence halt_s;
      instr_wr_s ##1 hwdata[15:0] == 16'h0003;
   endsequence
   sequence other_s;
      instr_wr_s ##1 hwdata[15:0] != 16'h0003;
   endsequence
   a_halt_effect: assert property (halt_s |->
      ##4 wdt_clear && osc_stop)
      else $error("halt did not clear watchdog and stop oscillator");
   a_no_clear: assert property (other_s |-> ##1 !wdt_clear [*4])
      else $error("watchdog cleared by a non-halt opcode");
   a_clear_pulse: assert property (wdt_clear |=> !wdt_clear)
      else $error("watchdog clear longer than one cycle");
   a_clear_stop: assert property ($rose(wdt_clear) |->
      $rose(osc_stop))
      else $error("watchdog clear without oscillator stop");
   a_wake_cause: assert property ($fell(osc_stop) |->
      $past(wake_any, 2))
      else $error("oscillator restarted without wake-up");
   a_rd_wait: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_wr_nowait: assert property (req && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
endmodule
bind sso_core sso_props u_props (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .wdt_clear(wdt_clear), .osc_stop(osc_stop),
   .wake_wdt(wake_wdt), .wake_evt(wake_evt)
);
`default_nettype wire

// >>> sim/sso_core_tb.sv
// sso_core_tb.sv: random and corner subtracts, halt and wake on sso_core
// assumes the bench is the only bus master, hready tied to hreadyout
`timescale 1ns/10ps
`default_nettype none
module sso_core_tb;
   logic        hclk, hresetn, hsel, hwrite, wake_wdt, wake_evt, c, dd;
   logic [31:0] haddr, hwdata, seed, rd;
   logic [1:0]  htrans, op;
   logic [2:0]  hsize, sz;
   logic [7:0]  a, w, f, fa;
   logic [11:0] r;
   wire         hreadyout, hresp, wdt_clear, osc_stop;
   wire  [31:0] hrdata;
   int          n_mismatch, n_checks, n_clr, n0;
   sso_core dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .wdt_clear(wdt_clear), .osc_stop(osc_stop),
      .wake_wdt(wake_wdt), .wake_evt(wake_evt)
   );
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      if (wdt_clear === 1'b1)
         n_clr <= n_clr + 1;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // returns {spill, nil, half, carry, difference}
   function automatic logic [11:0] sub8(input logic [7:0] x, y,
                                        input logic ci);
      int d, h, sd;
      d = int'(x) - int'(y) - int'(!ci);
      h = int'(x[3:0]) - int'(y[3:0]) - int'(!ci);
      sd = int'($signed(x)) - int'($signed(y)) - int'(!ci);
      return {sd > 127 || sd < -128, d[7:0] == 8'h00, h >= 0, d >= 0,
              d[7:0]};
   endfunction
   task automatic ahb(input logic wr, input logic [7:0] ad,
                      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, ad};
      hsize <= sz;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rchk(input string nm, input logic [7:0] ad,
                       input logic [31:0] e);
      ahb(1'b0, ad, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic idle();
      do ahb(1'b0, 8'h08, 32'h0); while (rd[6] !== 1'b0);
   endtask
   task automatic print_verdict();
      if (n_mismatch == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // about 25 cycles per case, 45 cases: 200 us is ample
   initial begin
      #200000;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      {hresetn, hsel, hwrite, wake_wdt, wake_evt} = 5'h00;
      {haddr, hwdata, htrans, hsize} = 69'h0;
      {n_mismatch, n_checks} = 64'h0;
      seed = 32'hEB55CAA3;
      sz = 3'h2;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rchk("work", 8'h04, 32'h0);
      rchk("status", 8'h08, 32'h30);
      rchk("unmapped", 8'h20, 32'h0);
      for (int i = 0; i < 45; i++) begin
         {a, w, f, c, dd, op} = 28'(rnd());
         op = op % 3;
         // hand-picked: zero, negative and signed overflow results
         if (i < 5) begin
            {op, a, w, c} = i == 4 ? {2'h2, 8'h03, 8'h0E, 1'b1} :
                            {2'h0, i == 3 ? 8'h80 : 8'h02, 8'(i + 1), c};
         end
         fa = {2'h1, f[3:0], 2'h0};
         r = sub8(a, w, op == 2'h2 ? c : 1'b1);
         ahb(1'b1, 8'h04, {24'h0, w});
         ahb(1'b1, fa, {24'h0, a});
         ahb(1'b1, 8'h08, {28'h0, 3'h0, c});
         ahb(1'b1, 8'h00, op == 2'h0 ? {16'h0, 8'hB2, a} :
             {16'h0, op == 2'h1 ? 7'h02 : 7'h01, dd, f});
         idle();
         dd = dd && op != 2'h0;
         rchk("work", 8'h04, {24'h0, dd ? w : r[7:0]});
         rchk("file", fa, {24'h0, dd ? r[7:0] : a});
         rchk("status", 8'h08, {28'h3, r[11:8]});
      end
      ahb(1'b1, 8'h04, 32'h22);
      // byte-sized write is ignored
      sz = 3'h0;
      ahb(1'b1, 8'h04, 32'h99);
      sz = 3'h2;
      rchk("work", 8'h04, 32'h22);
      ahb(1'b1, 8'h08, 32'h5);
      // undecodable opcode: no flag change, bad opcode shown
      ahb(1'b1, 8'h00, 32'h0001);
      idle();
      rchk("status", 8'h08, 32'h135);
      for (int k = 0; k < 2; k++) begin
         n0 = n_clr;
         ahb(1'b1, 8'h00, 32'h0003);
         repeat (6) @(posedge hclk);
         chk("clear_pulses", n0 + 1, n_clr);
         chk("osc_stop", 32'h1, {31'h0, osc_stop});
         rchk("status", 8'h08, 32'hA5);
         ahb(1'b1, 8'h00, 32'hB210);
         repeat (6) @(posedge hclk);
         rchk("work", 8'h04, 32'h22);
         if (k == 0)
            wake_wdt <= 1'b1;
         else
            wake_evt <= 1'b1;
         repeat (6) @(posedge hclk);
         {wake_evt, wake_wdt} <= 2'h0;
         repeat (2) @(posedge hclk);
         chk("osc_stop", 32'h0, {31'h0, osc_stop});
         rchk("status", 8'h08, k == 0 ? 32'h05 : 32'h25);
      end
      // reset while asleep wakes the core and restores status
      ahb(1'b1, 8'h00, 32'h0003);
      repeat (6) @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("osc_stop", 32'h0, {31'h0, osc_stop});
      rchk("status", 8'h08, 32'h30);
      rchk("work", 8'h04, 32'h0);
      print_verdict();
   end
endmodule
`default_nettype wire
